// >>> xcf_top.sv
module xcf_top (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              por_n,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire xcf_pkg::xcf_sys_s sys,
    input  wire logic              xtal_clk_in,
    input  wire logic              ulp_clk_in,
    output logic                   osc_run,
    output logic                   clk32k_en,
    output logic                   clk1k_en,
    output logic                   safe_clk_sel,
    output logic                   cfd_event,
    output logic                   irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]       ctrl;
        logic [7:0]        cfd;
        logic [2:0]        flag;
        logic [2:0]        inten;
        xcf_pkg::xcf_osc_e st;
        logic [18:0]       su_cnt;
        logic [2:0]        xs;
        logic [2:0]        us;
        logic [3:0]        miss;
        logic [7:0]        pre;
        logic [4:0]        kdiv;
        logic              rdy;
        logic              fail;
        logic              sw;
        logic              c32;
        logic              c1k;
        logic              sc;
        logic              ev;
        logic              aph;
        logic              awr;
        logic [7:0]        aadr;
        logic [31:0]       rd;
    } xcf_state_s;

    xcf_state_s s_q, s_d;
    logic por_q;
    logic por_seen;

    // power-on reset is separate, but a plain reset also stops the crystal
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            por_q <= 1'b1;
        end else begin
            por_q <= 1'b0;
        end
    end
    assign por_seen = por_q;

    function automatic logic rise(input logic [2:0] sy);
        return sy[1] & ~sy[2];
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic want;
        logic tick;
        logic ondem;
        logic [18:0] su_len;
        logic [31:0] rv;
        want   = 1'b0;
        tick   = 1'b0;
        ondem  = 1'b0;
        su_len = '0;
        rv     = '0;
        s_d    = s_q;
        s_d.xs = {s_q.xs[1:0], xtal_clk_in};
        s_d.us = {s_q.us[1:0], ulp_clk_in};
        s_d.ev = 1'b0;
        tick   = rise(s_q.xs);
        ondem  = s_q.ctrl[xcf_pkg::B_ONDEM];
        // run decision per cpu mode
        if (!s_q.ctrl[xcf_pkg::B_ENABLE]) begin
            want = 1'b0;
        end else if (sys.standby) begin
            want = (s_q.ctrl[xcf_pkg::B_STDBY] && !ondem) || sys.periph_req;
        end else begin
            want = !ondem || sys.periph_req;
        end
        su_len = 19'(1) << (xcf_pkg::SU_BASE_LOG + 32'(s_q.ctrl[xcf_pkg::B_TSEL +: xcf_pkg::W_TSEL]));
        unique case (s_q.st)
            xcf_pkg::OSC_OFF: begin
                s_d.su_cnt = '0;
                if (want) begin
                    s_d.st = xcf_pkg::OSC_START;
                end
            end
            xcf_pkg::OSC_START: begin
                if (!want) begin
                    s_d.st = xcf_pkg::OSC_OFF;
                end else if (tick) begin
                    s_d.su_cnt = s_q.su_cnt + 19'd1;
                    if (s_q.su_cnt + 19'd1 >= su_len) begin
                        s_d.st = xcf_pkg::OSC_RUN;
                    end
                end
            end
            xcf_pkg::OSC_RUN: begin
                if (!want) begin
                    s_d.st = xcf_pkg::OSC_OFF;
                end
            end
        endcase
        s_d.rdy = (s_q.st == xcf_pkg::OSC_RUN) && want;
        if (s_d.rdy && !s_q.rdy) begin
            s_d.flag[xcf_pkg::B_RDY] = 1'b1;
        end
        // 1 khz enable: one pulse per 32 crystal ticks
        if (tick) begin
            s_d.kdiv = s_q.kdiv + 5'd1;
        end
        // gate on the next ready so no pulse leaves in the cycle the oscillator stops, unless a power-on reset is what stops it
        s_d.c32 = s_d.rdy && s_q.ctrl[xcf_pkg::B_OUT32K] && tick;
        s_d.c1k = s_d.rdy && s_q.ctrl[xcf_pkg::B_OUT1K] && tick && (s_q.kdiv == '1);
        // failure detector, only while the crystal is meant to run
        if (s_q.cfd[xcf_pkg::B_CFDEN] && s_q.rdy) begin
            if (tick) begin
                s_d.miss = '0;
            end else if (rise(s_q.us) && s_q.miss != 4'(xcf_pkg::CFD_LIMIT)) begin
                s_d.miss = s_q.miss + 4'd1;
            end
            if (s_q.miss == 4'(xcf_pkg::CFD_LIMIT) && !s_q.fail) begin
                s_d.fail = 1'b1;
                s_d.sw   = 1'b1;
                s_d.flag[xcf_pkg::B_FAIL] = 1'b1;
                s_d.ev   = s_q.cfd[xcf_pkg::B_CFDEO];
            end
            if (tick && s_q.fail) begin
                s_d.fail = 1'b0;
            end
        end else begin
            s_d.miss = '0;
            s_d.fail = 1'b0;
        end
        // safe clock: ulp ticks divided by the prescaler
        if (rise(s_q.us)) begin
            if (s_q.pre >= (8'd1 << s_q.cfd[xcf_pkg::B_PRESC +: 3]) - 8'd1) begin
                s_d.pre = '0;
                s_d.sc  = 1'b1;
            end else begin
                s_d.pre = s_q.pre + 8'd1;
                s_d.sc  = 1'b0;
            end
        end else begin
            s_d.sc = 1'b0;
        end
        // ------------------------------------------------------------
        // ahb-lite slave, zero wait states
        // ------------------------------------------------------------
        if (s_q.aph && s_q.awr) begin
            unique case (s_q.aadr)
                xcf_pkg::OFS_CTRL:   s_d.ctrl  = hwdata;
                xcf_pkg::OFS_CFD:    s_d.cfd   = hwdata[7:0];
                xcf_pkg::OFS_INTFLG: s_d.flag  = s_d.flag & ~hwdata[2:0];
                xcf_pkg::OFS_INTEN:  s_d.inten = hwdata[2:0];
                default: ;
            endcase
            // switch back only once the crystal is healthy again
            if (s_q.aadr == xcf_pkg::OFS_CFD && hwdata[xcf_pkg::B_SWBACK] && !s_q.fail
                && s_q.rdy) begin
                s_d.sw = 1'b0;
            end
        end
        // events raised this cycle win over the clear
        if (s_d.rdy && !s_q.rdy) begin
            s_d.flag[xcf_pkg::B_RDY] = 1'b1;
        end
        if (s_q.miss == 4'(xcf_pkg::CFD_LIMIT) && !s_q.fail && s_q.cfd[xcf_pkg::B_CFDEN]
            && s_q.rdy) begin
            s_d.flag[xcf_pkg::B_FAIL] = 1'b1;
        end
        if (s_q.sw && !s_d.sw) begin
            s_d.flag[xcf_pkg::B_SWITCH] = 1'b1;
        end
        unique case (haddr[7:0])
            xcf_pkg::OFS_CTRL:   rv = s_q.ctrl;
            xcf_pkg::OFS_CFD:    rv = {24'h0, s_q.cfd};
            xcf_pkg::OFS_STATUS: rv = {29'h0, s_q.sw, s_q.fail, s_q.rdy};
            xcf_pkg::OFS_INTFLG: rv = {29'h0, s_q.flag};
            xcf_pkg::OFS_INTEN:  rv = {29'h0, s_q.inten};
            default:             rv = 32'h0;
        endcase
        s_d.aph = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1]) begin
            s_d.awr  = hwrite;
            s_d.aadr = haddr[7:0];
            s_d.rd   = hwrite ? 32'h0 : rv;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q      <= '0;
            s_q.ctrl <= xcf_pkg::CTRL_RST;
            s_q.st   <= xcf_pkg::OSC_OFF;
        end else begin
            s_q <= s_d;
            // a power-on reset also reloads ctrl and stops the crystal, as hresetn does
            if (por_seen) begin
                s_q.ctrl <= xcf_pkg::CTRL_RST;
                s_q.st   <= xcf_pkg::OSC_OFF;
            end
        end
    end

    assign hrdata       = s_q.rd;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign osc_run      = s_q.st != xcf_pkg::OSC_OFF;
    assign clk32k_en    = s_q.sw ? s_q.sc : s_q.c32;
    assign clk1k_en     = s_q.c1k;
    assign safe_clk_sel = s_q.sw;
    assign cfd_event    = s_q.ev;
    assign irq          = |(s_q.flag & s_q.inten);
endmodule // xcf_top

// >>> xcf_pkg.sv
package xcf_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CFD    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_INTFLG = 8'h0c;
    localparam logic [7:0] OFS_INTEN  = 8'h10;
    // ctrl fields
    localparam int B_ENABLE  = 1;
    localparam int B_OUT32K  = 2;
    localparam int B_OUT1K   = 3;
    localparam int B_STDBY   = 6;
    localparam int B_ONDEM   = 7;
    localparam int B_TSEL    = 8;
    localparam int W_TSEL    = 3;
    // cfd control fields
    localparam int B_CFDEN   = 0;
    localparam int B_SWBACK  = 1;
    localparam int B_CFDEO   = 2;
    localparam int B_PRESC   = 4;
    // status / irq bit positions
    localparam int B_RDY     = 0;
    localparam int B_FAIL    = 1;
    localparam int B_SWITCH  = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0080;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 40_000_000;
    localparam int CFD_LIMIT   = 8;     // ulp clock ticks without a crystal tick before failure
    localparam int SU_BASE_LOG = 11;    // start-up = 2^(base+sel) crystal ticks
    typedef enum logic [1:0] {OSC_OFF, OSC_START, OSC_RUN} xcf_osc_e;
    typedef struct packed {
        logic       standby;
        logic       periph_req;
    } xcf_sys_s;
endpackage

// >>> xcf_properties.sv
module xcf_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    input wire logic osc_run,
    input wire logic clk32k_en,
    input wire logic clk1k_en,
    input wire logic safe_clk_sel,
    input wire logic cfd_event,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_gate32; clk32k_en && !safe_clk_sel |-> osc_run; endproperty
    a_gate32: assert property (p_gate32) else $error("32k pulse while stopped");
    property p_gate1k; clk1k_en |-> osc_run; endproperty
    a_gate1k: assert property (p_gate1k) else $error("1k pulse while stopped");
    property p_pulse32; clk32k_en |=> !clk32k_en; endproperty
    a_pulse32: assert property (p_pulse32) else $error("32k pulse too long");
    property p_pulse1k; clk1k_en |=> !clk1k_en [*8]; endproperty
    a_pulse1k: assert property (p_pulse1k) else $error("1k pulses too close");
    property p_por; !por_n |=> !osc_run; endproperty
    a_por: assert property (p_por) else $error("oscillator survived power-on");
    property p_event; cfd_event |=> !cfd_event; endproperty
    a_event: assert property (p_event) else $error("event longer than a cycle");
    property p_irqrst; $rose(hresetn) |-> !irq && !safe_clk_sel; endproperty
    a_irqrst: assert property (p_irqrst) else $error("irq or switch after reset");
    // a switch can only follow a failure seen while the crystal was powered
    property p_switch; $rose(safe_clk_sel) |-> $past(osc_run); endproperty
    a_switch: assert property (p_switch) else $error("switch with detector idle");
endmodule // xcf_props

bind xcf_top xcf_props u_props (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .osc_run(osc_run),
    .clk32k_en(clk32k_en), .clk1k_en(clk1k_en), .safe_clk_sel(safe_clk_sel),
    .cfd_event(cfd_event), .irq(irq)
);

// >>> xcf_xtal_model.sv
module xcf_xtal_model #(
    parameter int XT_HALF = 100
) (
    input  wire logic osc_run,
    input  wire logic stall,
    output logic      xtal_clk,
    output logic      ulp_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // a stopped crystal parks low rather than freezing at its last level
    initial begin
        xtal_clk = 1'b0;
        forever #(XT_HALF) xtal_clk = osc_run && !stall && !xtal_clk;
    end
    initial begin
        ulp_clk = 1'b0;
        forever #130 ulp_clk = !ulp_clk;
    end
endmodule // xcf_xtal_model

// >>> tb_xtal32k_osc_with_clock_fail_detect.sv
module tb_xtal32k_osc_with_clock_fail_detect;
    timeunit 1ns;
    timeprecision 1ps;
    logic              hclk, hresetn, por_n, hsel, hwrite, stall;
    logic [31:0]       haddr, hwdata, hrdata, rd;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    xcf_pkg::xcf_sys_s sys;
    logic              hreadyout, hresp, xtal_clk, ulp_clk, osc_run, clk32k_en, clk1k_en;
    logic              safe_sel, cfd_event, irq;
    int                err_count = 0, num_checks = 0, n;

    xcf_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sys(sys), .xtal_clk_in(xtal_clk),
        .ulp_clk_in(ulp_clk), .osc_run(osc_run), .clk32k_en(clk32k_en), .clk1k_en(clk1k_en),
        .safe_clk_sel(safe_sel), .cfd_event(cfd_event), .irq(irq)
    );
    xcf_xtal_model u_xtal (.osc_run(osc_run), .stall(stall), .xtal_clk(xtal_clk), .ulp_clk(ulp_clk));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, 0);
    endtask

    task automatic wait_run(input logic v);
        n = 0;
        while (osc_run !== v && n < 8) begin
            @(posedge hclk);
            n++;
        end
    endtask

    task automatic t_table;
        logic [15:0] tab [8] = '{16'h8200, 16'h8203, 16'h0201, 16'h0204,
                                16'h4205, 16'hc204, 16'hc207, 16'h0002};
        bus(0, xcf_pkg::OFS_CTRL, 0);
        chk(rd, 32'h80);
        bus(1, 8'h14, 32'hffff_ffff);
        bus(0, 8'h14, 0);
        chk(rd, 0);
        foreach (tab[i]) begin
            bus(1, xcf_pkg::OFS_CTRL, {24'h0, tab[i][15:8]});
            sys.standby    <= tab[i][2];
            sys.periph_req <= tab[i][1];
            @(posedge hclk);
            wait_run(tab[i][0]);
            chk(osc_run, tab[i][0]);
        end
        $display("t_table done");
    endtask

    task automatic t_start;
        bus(1, xcf_pkg::OFS_INTEN, 0);
        sys <= '0;
        bus(1, xcf_pkg::OFS_CTRL, 32'h0e);
        n = 0;
        while (clk32k_en !== 1'b1 && n < 20000) begin
            @(posedge hclk);
            n++;
        end
        chk(n > 16380 && n < 16420, 1);
        bus(0, xcf_pkg::OFS_STATUS, 0);
        chk(rd[0], 1);
        chk(irq, 0);
        bus(1, xcf_pkg::OFS_INTEN, 1);
        @(posedge hclk);
        chk(irq, 1);
        bus(1, xcf_pkg::OFS_INTFLG, 1);
        @(posedge hclk);
        chk(irq, 0);
        // crystal tick every 8 cycles, 1k pulse every 32 ticks: 4 pulses per 1024 cycles
        n = 0;
        repeat (1024) begin
            @(posedge hclk);
            if (clk1k_en === 1'b1) n++;
        end
        chk(n, 4);
        $display("t_start done");
    endtask

    task automatic t_fail;
        bus(1, xcf_pkg::OFS_INTEN, 2);
        bus(1, xcf_pkg::OFS_CFD, 32'h15);
        stall <= 1'b1;
        n = 0;
        while (cfd_event !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        chk(n > 70 && n < 115, 1);
        @(posedge hclk);
        chk(safe_sel, 1);
        chk(irq, 1);
        bus(0, xcf_pkg::OFS_STATUS, 0);
        chk(rd & 32'h6, 32'h6);
        n = 0;
        // safe clock divided by two: one pulse per 520 ns
        repeat (2600) begin
            @(posedge hclk);
            if (clk32k_en === 1'b1) n++;
        end
        chk(n > 123 && n < 127, 1);
        stall <= 1'b0;
        repeat (100) @(posedge hclk);
        bus(1, xcf_pkg::OFS_CFD, 32'h17);
        repeat (8) @(posedge hclk);
        chk(safe_sel, 0);
        bus(1, xcf_pkg::OFS_INTFLG, 32'h7);
        $display("t_fail done");
    endtask

    task automatic t_stop;
        bus(1, xcf_pkg::OFS_CTRL, 0);
        wait_run(0);
        bus(0, xcf_pkg::OFS_STATUS, 0);
        chk(rd[0], 0);
        bus(1, xcf_pkg::OFS_CTRL, 32'h02);
        wait_run(1);
        por_n <= 1'b0;
        @(posedge hclk);
        por_n <= 1'b1;
        @(posedge hclk);
        chk(osc_run, 0);
        $display("t_stop done");
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        {hresetn, por_n, hsel, hwrite, stall} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        sys = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        por_n   <= 1'b1;
        @(posedge hclk);
        t_table();
        t_start();
        t_fail();
        t_stop();
        complete_run();
    end
    // the start-up wait dominates the run at about 16k cycles
    initial begin
        repeat (60000) @(posedge hclk);
        err_count++;
        complete_run();
    end
endmodule // tb_xtal32k_osc_with_clock_fail_detect
